// File: rtl/synth_register_host_port.sv
// host register port and minimal sound engine of the three-voice synthesizer
//
// Function
// R1 - chip clear held low ten master clocks zeroes registers, silences audio
// R2 - oscillators and envelope advance only on master clock edges
// R3 - transfers happen only while the master clock is high
// R4 - direction high reads the indexed register, low writes it
// R5 - chip select high: no write accepted, no read data driven
// R6 - read only when select low, master clock high, direction high
// R7 - write only when select low, master clock high, direction low
// R8 - five index lines reach 29 registers; three locations unimplemented
// R9 - writes to unimplemented locations ignored; reads give meaningless data
// R10 - data drivers off whenever no read is in progress
// R11 - during a write drivers stay off; host drives the data
// R12 - during a read drivers on with the indexed register contents
// R13 - write data latched at the master clock fall ending the write
`timescale 1ns/1ns
`include "synth_port_consts.svh"

module synth_register_host_port
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic master_clk,
   input wire logic chip_clear_n,
   input wire logic chip_select_n,
   input wire logic rd_wr,
   input wire logic [4:0] register_index,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_oe,
   input wire logic [7:0] pot_x_value,
   input wire logic [7:0] pot_y_value,
   output logic [7:0] audio_level
);

   logic rst_meta_ff;
   logic rst_sync_ff;
   logic rst_sync_n;
   logic mclk_q_ff;
   logic mclk_rise;
   logic mclk_fall;
   logic [3:0] clear_cnt_ff;
   logic clear_active;
   logic rd_qual;
   logic wr_qual;
   logic [7:0] data_out_ff;
   logic data_oe_ff;
   logic [7:0] rd_value;
   logic wr_pend_ff;
   logic [4:0] wr_idx_ff;
   logic [7:0] wr_data_ff;
   logic wr_commit;
   logic bank_we;
   logic [`REG_FLAT_W-1:0] regs_flat;
   logic [23:0] acc_ff [0:2];
   logic [7:0] pot_x_ff;
   logic [7:0] pot_y_ff;
   logic [7:0] env3_ff;
   logic [11:0] env_div_ff;
   synth_port_pkg::env_dir_t env_dir_ff;
   logic [11:0] env_period;
   logic [7:0] v3_ctrl;
   logic [7:0] v3_atk_dec;
   logic [7:0] v3_sus_rel;
   logic [7:0] mode_vol;
   logic [9:0] mix_sum;
   logic [13:0] mix_scaled;
   logic [7:0] audio_ff;

   // one byte out of the flattened register array
   function automatic logic [7:0] get_reg(input logic [`REG_FLAT_W-1:0] flat, input logic [4:0] idx);
      get_reg = flat[{idx, 3'b000} +: 8];
   endfunction : get_reg

   // 16-bit frequency word of a voice
   function automatic logic [15:0] get_freq(input logic [`REG_FLAT_W-1:0] flat, input logic [4:0] base);
      get_freq = {get_reg(flat, base + `OFS_FREQ_HI), get_reg(flat, base + `OFS_FREQ_LO)};
   endfunction : get_freq

   // reset release through two flops; asynchronous assert
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rst_sync_n = rst_sync_ff;

   // master clock edges seen in the system clock domain
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         mclk_q_ff <= 1'b0;
      else
         mclk_q_ff <= master_clk;
   end
   assign mclk_rise = master_clk && !mclk_q_ff;
   assign mclk_fall = !master_clk && mclk_q_ff;

   // R1 chip clear timing
   // counts master rises while held low; a short glitch clears nothing
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         clear_cnt_ff <= 4'h0;
      else if (chip_clear_n)
         clear_cnt_ff <= 4'h0;
      else if (mclk_rise && clear_cnt_ff != `CLEAR_CYCLES)
         clear_cnt_ff <= clear_cnt_ff + 4'h1;
   end
   assign clear_active = !chip_clear_n && clear_cnt_ff == `CLEAR_CYCLES;

   // R3 clock high qualifies transfers
   // R6 read qualifier
   // R4 direction picks read or write
   // R7 write qualifier
   assign rd_qual = !chip_select_n && master_clk && rd_wr;
   assign wr_qual = !chip_select_n && master_clk && !rd_wr;

   // R8 index decode for reads
   // write-only and unused locations read as zero (host must not rely on it)
   always_comb
   begin
      rd_value = `DATA_IDLE;
      unique case (register_index)
         `IDX_POT_X: rd_value = pot_x_ff;
         `IDX_POT_Y: rd_value = pot_y_ff;
         `IDX_OSC3: rd_value = acc_ff[2][23:16];
         `IDX_ENV3: rd_value = env3_ff;
         default: rd_value = `DATA_IDLE;
      endcase
   end

   // R12 drive read data
   // R10 drivers off otherwise; one system clock of latency keeps outputs registered
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         data_out_ff <= `DATA_IDLE;
         data_oe_ff <= 1'b0;
      end
      else
      begin
         data_oe_ff <= rd_qual;
         data_out_ff <= rd_qual ? rd_value : `DATA_IDLE;
      end
   end
   assign host_data_out = data_out_ff;
   assign host_data_oe = data_oe_ff;

   // R11 sample host data during write
   // R13 commit on the falling edge; last sampled value wins
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         wr_pend_ff <= 1'b0;
         wr_idx_ff <= 5'h00;
         wr_data_ff <= `DATA_IDLE;
      end
      else if (clear_active)
         wr_pend_ff <= 1'b0;
      else if (wr_qual)
      begin
         wr_pend_ff <= 1'b1;
         wr_idx_ff <= register_index;
         wr_data_ff <= host_data_in;
      end
      else if (mclk_fall)
         wr_pend_ff <= 1'b0;
   end
   assign wr_commit = wr_pend_ff && mclk_fall && !clear_active;

   // R9 unimplemented and read-only locations never reach storage
   assign bank_we = wr_commit && wr_idx_ff <= `IDX_WR_LAST;

   reg_bank u_reg_bank
   (
      .clk(sys_clk),
      .rst_n(rst_sync_n),
      .clear(clear_active),
      .we(bank_we),
      .idx(wr_idx_ff),
      .wdata(wr_data_ff),
      .regs_flat(regs_flat)
   );

   // R2 phase accumulators step once per master clock
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         for (int v = 0; v < 3; v++)
            acc_ff[v] <= `ACC_RESET;
      end
      else if (clear_active)
      begin
         for (int v = 0; v < 3; v++)
            acc_ff[v] <= `ACC_RESET;
      end
      else if (mclk_rise)
      begin
         acc_ff[0] <= acc_ff[0] + {8'h00, get_freq(regs_flat, `IDX_V1_BASE)};
         acc_ff[1] <= acc_ff[1] + {8'h00, get_freq(regs_flat, `IDX_V2_BASE)};
         acc_ff[2] <= acc_ff[2] + {8'h00, get_freq(regs_flat, `IDX_V3_BASE)};
      end
   end

   // pot readings refresh on master clock; cleared with everything else
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         pot_x_ff <= `REG_RESET;
         pot_y_ff <= `REG_RESET;
      end
      else if (clear_active)
      begin
         pot_x_ff <= `REG_RESET;
         pot_y_ff <= `REG_RESET;
      end
      else if (mclk_rise)
      begin
         pot_x_ff <= pot_x_value;
         pot_y_ff <= pot_y_value;
      end
   end

   // control bytes pulled out once; a select on a call result is not portable
   assign v3_ctrl = get_reg(regs_flat, `IDX_V3_BASE + `OFS_CTRL);
   assign v3_atk_dec = get_reg(regs_flat, `IDX_V3_BASE + `OFS_ATK_DEC);
   assign v3_sus_rel = get_reg(regs_flat, `IDX_V3_BASE + `OFS_SUS_REL);
   assign mode_vol = get_reg(regs_flat, `IDX_MODE_VOL);

   // envelope period: attack nibble while gated, release nibble otherwise
   assign env_period = v3_ctrl[`CTRL_GATE_BIT] ? {8'h00, v3_atk_dec[7:4]} * `ENV_STEP + `ENV_STEP
                                               : {8'h00, v3_sus_rel[3:0]} * `ENV_STEP + `ENV_STEP;

   // R2 voice three envelope, rate counted in master clocks
   // linear ramp only; the real decay curve is traded for size
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         env3_ff <= `REG_RESET;
         env_div_ff <= 12'h000;
         env_dir_ff <= synth_port_pkg::ENV_FALL;
      end
      else if (clear_active)
      begin
         env3_ff <= `REG_RESET;
         env_div_ff <= 12'h000;
         env_dir_ff <= synth_port_pkg::ENV_FALL;
      end
      else if (mclk_rise)
      begin
         env_dir_ff <= v3_ctrl[`CTRL_GATE_BIT] ? synth_port_pkg::ENV_RISE : synth_port_pkg::ENV_FALL;
         if (env_div_ff + 12'h001 >= env_period)
         begin
            env_div_ff <= 12'h000;
            unique case (env_dir_ff)
               synth_port_pkg::ENV_RISE:
                  if (env3_ff != `ENV_MAX)
                     env3_ff <= env3_ff + 8'h01;
               synth_port_pkg::ENV_FALL:
                  if (env3_ff != `REG_RESET)
                     env3_ff <= env3_ff - 8'h01;
            endcase
         end
         else
         begin
            env_div_ff <= env_div_ff + 12'h001;
         end
      end
   end

   // sawtooth mix, voice three removable, scaled by master volume
   always_comb
   begin
      mix_sum = {2'b00, acc_ff[0][23:16]} + {2'b00, acc_ff[1][23:16]};
      if (!mode_vol[`MODE_V3_OFF_BIT])
         mix_sum = mix_sum + {2'b00, acc_ff[2][23:16]};
      mix_scaled = mix_sum * mode_vol[3:0];
   end

   // R1 silence while chip clear is in force
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         audio_ff <= `REG_RESET;
      else if (clear_active)
         audio_ff <= `REG_RESET;
      else
         audio_ff <= mix_scaled[13:6];
   end
   assign audio_level = audio_ff;

   clear_silent_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R1
      clear_active |=> audio_level == 8'h00 && acc_ff[0] == 24'h00_0000)
      else $error("audio not silenced by chip clear");
   clear_count_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R1
      clear_active |-> !chip_clear_n && clear_cnt_ff == 4'hA)
      else $error("chip clear active too early");
   osc_step_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R2
      !mclk_rise && !clear_active |=> acc_ff[0] == $past(acc_ff[0]))
      else $error("oscillator moved without master clock edge");
   read_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R12
      rd_qual |=> host_data_oe && host_data_out == $past(rd_value))
      else $error("read data not driven");
   drive_only_read_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R10
      host_data_oe |-> $past(!chip_select_n && master_clk && rd_wr))
      else $error("data driven outside a read");
   deselect_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R5
      chip_select_n |=> !host_data_oe ##0 !$rose(wr_pend_ff))
      else $error("activity while deselected");
   write_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R7
      wr_qual && !clear_active |=> wr_pend_ff && wr_data_ff == $past(host_data_in) && !host_data_oe)
      else $error("write data not sampled");
   commit_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R13
      bank_we |-> !master_clk && mclk_q_ff && wr_pend_ff)
      else $error("write committed off the falling edge");
   unused_ignored_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // R9
      wr_commit && wr_idx_ff > `IDX_WR_LAST |=> regs_flat == $past(regs_flat))
      else $error("write to unimplemented location stored");

endmodule : synth_register_host_port

// File: rtl/synth_port_consts.svh
// register map, field positions and timing counts of the synthesizer host port
`ifndef SYNTH_PORT_CONSTS_SVH
`define SYNTH_PORT_CONSTS_SVH

// register indices as seen on the five index lines
`define IDX_V1_BASE 5'h00
`define IDX_V2_BASE 5'h07
`define IDX_V3_BASE 5'h0E
`define OFS_FREQ_LO 5'h00
`define OFS_FREQ_HI 5'h01
`define OFS_CTRL 5'h04
`define OFS_ATK_DEC 5'h05
`define OFS_SUS_REL 5'h06
`define IDX_MODE_VOL 5'h18
`define IDX_POT_X 5'h19
`define IDX_POT_Y 5'h1A
`define IDX_OSC3 5'h1B
`define IDX_ENV3 5'h1C
`define IDX_WR_LAST 5'h18
`define IDX_IMPL_LAST 5'h1C
`define NUM_WR_REGS 25
`define REG_FLAT_W 200

// field positions
`define CTRL_GATE_BIT 0
`define MODE_V3_OFF_BIT 7

// reset and idle values
`define REG_RESET 8'h00
`define ACC_RESET 24'h00_0000
`define DATA_IDLE 8'h00

// chip clear needs this many master clock periods held low
`define CLEAR_CYCLES 4'hA
// master clock periods per envelope step for each rate unit
`define ENV_STEP 12'h010
`define ENV_MAX 8'hFF

`endif

// File: rtl/synth_port_pkg.sv
// types shared by the synthesizer host port
package synth_port_pkg;

   // host port transfer state, one-hot
   typedef enum logic [2:0] {
      PORT_IDLE = 3'b001,
      PORT_READ = 3'b010,
      PORT_WRITE = 3'b100
   } port_state_t;

   // envelope direction, one-hot
   typedef enum logic [1:0] {
      ENV_RISE = 2'b01,
      ENV_FALL = 2'b10
   } env_dir_t;

endpackage : synth_port_pkg

// File: rtl/reg_bank.sv
// write-only control register array of the synthesizer
`timescale 1ns/1ns
`include "synth_port_consts.svh"

module reg_bank
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic we,
   input wire logic [4:0] idx,
   input wire logic [7:0] wdata,
   output logic [`REG_FLAT_W-1:0] regs_flat
);

   logic [7:0] regs_ff [0:`NUM_WR_REGS-1];

   // storage; chip clear beats a write landing in the same cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < `NUM_WR_REGS; i++)
            regs_ff[i] <= `REG_RESET;
      end
      else if (clear)
      begin
         for (int i = 0; i < `NUM_WR_REGS; i++)
            regs_ff[i] <= `REG_RESET;
      end
      else if (we && idx <= `IDX_WR_LAST)
      begin
         regs_ff[idx] <= wdata;
      end
   end

   // flatten for the engine, lowest index in the low byte
   always_comb
   begin
      regs_flat = '0;
      for (int i = 0; i < `NUM_WR_REGS; i++)
         regs_flat[i*8 +: 8] = regs_ff[i];
   end

endmodule : reg_bank

// File: verif/host_cpu_model.sv
// host processor model driving the synthesizer register port
`timescale 1ns/1ns

module host_cpu_model
(
   input wire logic sys_clk,
   output logic master_clk,
   output logic chip_clear_n,
   output logic chip_select_n,
   output logic rd_wr,
   output logic [4:0] register_index,
   output logic [7:0] host_data_in,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe
);
   logic [7:0] wdata_ff;
   logic drive_ff;
   logic [7:0] last_bus_ff;

   // resolved data wire; an undriven bus toggles so stale bytes never pass
   assign host_data_in = host_data_oe ? host_data_out : (drive_ff ? wdata_ff : ~last_bus_ff);

   // idle levels at time zero
   initial
   begin
      master_clk = 1'b0;
      chip_clear_n = 1'b1;
      chip_select_n = 1'b1;
      rd_wr = 1'b1;
      register_index = 5'h00;
      wdata_ff = 8'h00;
      drive_ff = 1'b0;
      last_bus_ff = 8'h00;
   end

   // remember the wire for the floating pattern
   always @(posedge sys_clk)
   begin
      last_bus_ff <= host_data_in;
   end

   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : wait_n

   // free master clock rises with the port deselected
   task automatic idle(input int n);
      repeat (n)
      begin
         master_clk = 1'b1;
         wait_n(2);
         master_clk = 1'b0;
         wait_n(2);
      end
   endtask : idle

   // one bus cycle; hi is at least 3 clocks of qualifier phase
   task automatic cycle(input logic cs_n, input logic rw, input logic mlvl, input logic [4:0] idx,
      input logic [7:0] wd, input int hi, output logic [7:0] first, output logic [7:0] last,
      output logic oe_hi, output logic oe_after);
      master_clk = 1'b0;
      wait_n(2);
      master_clk = mlvl;
      chip_select_n = cs_n;
      rd_wr = rw;
      register_index = idx;
      wdata_ff = wd;
      drive_ff = ~rw;
      wait_n(3);
      first = host_data_out;
      wait_n(hi - 3);
      last = host_data_out;
      oe_hi = host_data_oe;
      // index and data held one clock past the fall
      master_clk = 1'b0;
      wait_n(1);
      chip_select_n = 1'b1;
      rd_wr = 1'b1;
      drive_ff = 1'b0;
      wait_n(3);
      oe_after = host_data_oe;
   endtask : cycle

   task automatic clear_hold(input int n);
      chip_clear_n = 1'b0;
      wait_n(1);
      idle(n);
   endtask : clear_hold

   task automatic clear_release();
      chip_clear_n = 1'b1;
      wait_n(2);
   endtask : clear_release
endmodule : host_cpu_model

// File: verif/synth_register_host_port_bench.sv
// self-checking bench for the synthesizer host register port
`timescale 1ns/1ns

module synth_register_host_port_bench;
   logic sys_clk;
   logic rst_n;
   logic master_clk;
   logic chip_clear_n;
   logic chip_select_n;
   logic rd_wr;
   logic [4:0] register_index;
   logic [7:0] host_data_in;
   logic [7:0] host_data_out;
   logic host_data_oe;
   logic [7:0] pot_x_value;
   logic [7:0] pot_y_value;
   logic [7:0] audio_level;
   logic [7:0] r_first;
   logic [7:0] r_last;
   logic r_oe;
   logic r_idle;
   int n_mismatch = 0;
   int num_checks = 0;

   synth_register_host_port u_synth_register_host_port
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .master_clk(master_clk),
      .chip_clear_n(chip_clear_n),
      .chip_select_n(chip_select_n),
      .rd_wr(rd_wr),
      .register_index(register_index),
      .host_data_in(host_data_in),
      .host_data_out(host_data_out),
      .host_data_oe(host_data_oe),
      .pot_x_value(pot_x_value),
      .pot_y_value(pot_y_value),
      .audio_level(audio_level)
   );

   host_cpu_model u_host_cpu_model
   (
      .sys_clk(sys_clk),
      .master_clk(master_clk),
      .chip_clear_n(chip_clear_n),
      .chip_select_n(chip_select_n),
      .rd_wr(rd_wr),
      .register_index(register_index),
      .host_data_in(host_data_in),
      .host_data_out(host_data_out),
      .host_data_oe(host_data_oe)
   );

   // 25 MHz system clock
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic xfer(input logic cs_n, input logic rw, input logic mlvl, input logic [4:0] idx,
      input logic [7:0] wd, input int hi);
      u_host_cpu_model.cycle(cs_n, rw, mlvl, idx, wd, hi, r_first, r_last, r_oe, r_idle);
   endtask : xfer

   task automatic t_after_reset();
      chk_bit(host_data_oe, 1'b0);
      chk_byte(audio_level, 8'h00);
      $display("test after_reset done");
   endtask : t_after_reset

   // pot registers are the only reads with a fixed answer
   task automatic t_pot_read();
      xfer(1'b0, 1'b1, 1'b1, 5'h19, 8'h00, 4);
      chk_byte(r_last, 8'h5A);
      chk_bit(r_oe, 1'b1);
      chk_bit(r_idle, 1'b0);
      xfer(1'b0, 1'b1, 1'b1, 5'h1A, 8'h00, 4);
      chk_byte(r_last, 8'hC3);
      xfer(1'b0, 1'b1, 1'b1, 5'h1D, 8'h00, 4);
      chk_bit(r_oe, 1'b1);
      // new pot readings must show after the next master rise
      pot_x_value = 8'h3C;
      pot_y_value = 8'h96;
      xfer(1'b0, 1'b1, 1'b1, 5'h1A, 8'h00, 4);
      chk_byte(r_last, 8'h96);
      $display("test pot_read done");
   endtask : t_pot_read

   task automatic t_refused();
      xfer(1'b1, 1'b1, 1'b1, 5'h19, 8'h00, 4);
      chk_bit(r_oe, 1'b0);
      xfer(1'b0, 1'b1, 1'b0, 5'h19, 8'h00, 4);
      chk_bit(r_oe, 1'b0);
      xfer(1'b0, 1'b0, 1'b1, 5'h19, 8'hFF, 4);
      chk_bit(r_oe, 1'b0);
      xfer(1'b0, 1'b1, 1'b1, 5'h19, 8'h00, 4);
      chk_byte(r_last, 8'h3C);
      $display("test refused done");
   endtask : t_refused

   // voice three frequency must stay zero, so oscillator readback stays zero
   task automatic t_write_gating();
      xfer(1'b1, 1'b0, 1'b1, 5'h0F, 8'h80, 4);
      xfer(1'b0, 1'b0, 1'b0, 5'h0F, 8'h80, 4);
      for (int i = 5'h1D; i <= 5'h1F; i++)
         xfer(1'b0, 1'b0, 1'b1, i[4:0], 8'h80, 4);
      u_host_cpu_model.idle(4);
      xfer(1'b0, 1'b1, 1'b1, 5'h1B, 8'h00, 4);
      chk_byte(r_last, 8'h00);
      $display("test write_gating done");
   endtask : t_write_gating

   task automatic t_write_accept();
      xfer(1'b0, 1'b0, 1'b1, 5'h0F, 8'h80, 4);
      chk_bit(r_oe, 1'b0);
      xfer(1'b0, 1'b0, 1'b1, 5'h18, 8'h0F, 4);
      u_host_cpu_model.idle(4);
      // six master rises at step 0x8000 after the write landed
      xfer(1'b0, 1'b1, 1'b1, 5'h1B, 8'h00, 8);
      chk_byte(r_last, 8'h03);
      chk_byte(r_first, 8'h03);
      $display("test write_accept done");
   endtask : t_write_accept

   // a nine-rise pulse is too short; ten clears everything
   task automatic t_clear();
      u_host_cpu_model.clear_hold(9);
      u_host_cpu_model.clear_release();
      xfer(1'b0, 1'b1, 1'b1, 5'h1B, 8'h00, 4);
      chk_byte(r_last, 8'h08);
      chk_byte(audio_level, 8'h01);
      u_host_cpu_model.clear_hold(10);
      chk_byte(audio_level, 8'h00);
      chk_bit(host_data_oe, 1'b0);
      u_host_cpu_model.clear_release();
      u_host_cpu_model.idle(4);
      chk_byte(audio_level, 8'h00);
      xfer(1'b0, 1'b1, 1'b1, 5'h1B, 8'h00, 4);
      chk_byte(r_last, 8'h00);
      // gate voice three: one step lands at the sixteenth rise after the clear
      xfer(1'b0, 1'b0, 1'b1, 5'h12, 8'h01, 4);
      u_host_cpu_model.idle(20);
      xfer(1'b0, 1'b1, 1'b1, 5'h1C, 8'h00, 4);
      chk_byte(r_last, 8'h01);
      $display("test clear done");
   endtask : t_clear

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // watchdog well beyond the few hundred clocks the tests need
   initial
   begin
      #(40 * 50000);
      n_mismatch++;
      conclude();
   end

   // main sequence
   initial
   begin
      rst_n = 1'b0;
      pot_x_value = 8'h5A;
      pot_y_value = 8'hC3;
      repeat (20) @(posedge sys_clk);
      #2;
      rst_n = 1'b1;
      u_host_cpu_model.wait_n(4);
      t_after_reset();
      t_pot_read();
      t_refused();
      t_write_gating();
      t_write_accept();
      t_clear();
      conclude();
   end
endmodule : synth_register_host_port_bench
